// ==== design/fcd_pkg.sv ====
// Purpose: constants and types for the fieldbus control word decoder
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bit positions are those of the two control word layouts
package fcd_pkg;

   // widths
   localparam int CW_W      = 32;
   localparam int REF_W     = 16;
   localparam int PROF_W    = 8;
   localparam int USER_W    = 4;
   localparam int LOW_W     = 16;

   // profile selection values
   localparam logic [PROF_W-1:0] PROF_SEL_CONV = 8'h00;
   localparam logic [PROF_W-1:0] PROF_SEL_PASS = 8'h05;

   // converting profile, upper byte
   localparam int CV_JOG1   = 8;
   localparam int CV_JOG2   = 9;
   localparam int CV_REMOTE = 10;
   localparam int CV_EXTLOC = 11;
   localparam int CV_USER   = 12;

   // pass-through profile
   localparam int PT_STOP   = 0;
   localparam int PT_START  = 1;
   localparam int PT_REV    = 2;
   localparam int PT_RESET  = 4;
   localparam int PT_EXTLOC = 5;
   localparam int PT_RUNDIS = 6;
   localparam int PT_SMRAMP = 7;
   localparam int PT_SMFAST = 8;
   localparam int PT_SMFREE = 9;
   localparam int PT_ROZERO = 11;
   localparam int PT_RHOLD  = 12;
   localparam int PT_RIZERO = 13;
   localparam int PT_TKCMD  = 16;
   localparam int PT_TKREF  = 17;
   localparam int PT_USER   = 22;

   // bits 3, 10, 15, 18..21, 26..31
   localparam logic [CW_W-1:0] PT_RSVD_MASK = 32'hFC3C_8408;

   // reset values
   localparam logic [CW_W-1:0]   CW_RST   = 32'h0000_0000;
   localparam logic [REF_W-1:0]  REF_RST  = 16'h0000;
   localparam logic [USER_W-1:0] USER_RST = 4'h0;
   localparam logic              RUN_RST  = 1'b1;

   typedef enum logic [1:0] {
      SM_CONFIG,
      SM_RAMP,
      SM_FAST,
      SM_FREE
   } fcd_stop_t;

   typedef enum logic [1:0] {
      PROF_NONE,
      PROF_CONV,
      PROF_PASS
   } fcd_prof_t;

endpackage

// ==== design/fcd_stop_resolve.sv ====
// Purpose: resolve the stop mode from the three request bits
// Assumes: purely combinational, request inputs from the incoming unregistered word
// Notes:   more than one request bit set resolves to the harshest stop
`timescale 1ns/1ps
module fcd_stop_resolve
   import fcd_pkg::*;
(
   input  wire logic      sel_ramp,
   input  wire logic      sel_fast,
   input  wire logic      sel_free,
   input  wire fcd_stop_t cfg_mode,
   output fcd_stop_t      mode
);

   // explicit request wins, else configured mode
   always_comb
   begin
      if (sel_free)
         mode = SM_FREE;
      else if (sel_fast)
         mode = SM_FAST;
      else if (sel_ramp)
         mode = SM_RAMP;
      else if (cfg_mode == SM_CONFIG)
         mode = SM_RAMP;
      else
         mode = cfg_mode;
   end

endmodule

// ==== design/fcd_decoder.sv ====
// Purpose: decode fieldbus control words for both control profiles
// Assumes: words and reference arrive as one-cycle strobed data on clk_sys
// Notes:   all decoded outputs are registered; profile change returns them to reset values
`timescale 1ns/1ps

// Notes on behaviour
// - profile value 0 converts, 5 passes through
// - converting bit 8 requests first jog speed
// - converting bit 9 requests second jog speed
// - bit 10 enables bus; else nonzero retains
// - bit 10 clear, all zero: enable, locked
// - converting bit 11 selects second external location
// - four user bits, 12-15 or 22-25
// - pass-through copies low 16 bits unchanged
// - bit 0 stops using resolved stop mode
// - bit 1 starts, bit 2 reverses
// - bit 4 rising edge resets active fault
// - pass-through bit 5 selects second location
// - bit 6 set disables run enable
// - bits 7-9 pick stop mode, else configured
// - bit 11 forces ramp output to zero
// - bit 12 freezes ramp output
// - bit 13 forces ramp input to zero
// - bit 16 takes over command source
// - bit 17 takes over reference source
// - reserved bits have no function
module fcd_decoder
   import fcd_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              rst,
   input  wire logic [PROF_W-1:0] profile_cfg,
   input  wire logic              cw_valid,
   input  wire logic [CW_W-1:0]   cw_data,
   input  wire logic [REF_W-1:0]  ref_data,
   input  wire logic              jog_src_bus,
   input  wire logic              loc_src_bus,
   input  wire logic              run_src_bus,
   input  wire fcd_stop_t         cfg_stop_mode,
   input  wire logic              fault_active,
   output fcd_prof_t              profile_q,
   output logic                   cw_taken_q,
   output logic                   cw_retained_q,
   output logic [CW_W-1:0]        control_word_q,
   output logic [REF_W-1:0]       reference_q,
   output logic                   bus_ctrl_en_q,
   output logic                   ref_locked_q,
   output logic                   ramp_locked_q,
   output logic                   jog1_q,
   output logic                   jog2_q,
   output logic                   external_location_select_q,
   output logic [USER_W-1:0]      user_bits_q,
   output logic [CW_W-1:0]        internal_cw_q,
   output logic                   stop_req_q,
   output fcd_stop_t              stop_mode_q,
   output logic                   start_req_q,
   output logic                   reverse_req_q,
   output logic                   fault_reset_q,
   output logic                   run_enable_q,
   output logic                   ramp_out_zero_q,
   output logic                   ramp_hold_q,
   output logic                   ramp_in_zero_q,
   output logic                   bus_takeover_command_q,
   output logic                   bus_takeover_reference_q,
   output logic                   reserved_seen_q
);

   // a control bit only acts when the bus is its configured source
   function automatic logic src_gate(input logic from_bus, input logic b);
      return from_bus & b;
   endfunction

   // map the configuration value to a profile
   function automatic fcd_prof_t prof_decode(input logic [PROF_W-1:0] v);
      fcd_prof_t p;
      p = PROF_NONE;
      if (v == PROF_SEL_CONV)
         p = PROF_CONV;
      else if (v == PROF_SEL_PASS)
         p = PROF_PASS;
      return p;
   endfunction

   fcd_prof_t           profile_d;
   logic                cw_taken_d;
   logic                cw_retained_d;
   logic [CW_W-1:0]     control_word_d;
   logic [REF_W-1:0]    reference_d;
   logic                bus_ctrl_en_d;
   logic                ref_locked_d;
   logic                ramp_locked_d;
   logic                jog1_d;
   logic                jog2_d;
   logic                ext_loc_d;
   logic [USER_W-1:0]   user_bits_d;
   logic [CW_W-1:0]     internal_cw_d;
   logic                stop_req_d;
   fcd_stop_t           stop_mode_d;
   logic                start_req_d;
   logic                reverse_req_d;
   logic                fault_reset_d;
   logic                run_enable_d;
   logic                ramp_out_zero_d;
   logic                ramp_hold_d;
   logic                ramp_in_zero_d;
   logic                take_cmd_d;
   logic                take_ref_d;
   logic                reserved_seen_d;
   logic                reset_bit_q;
   logic                reset_bit_d;
   fcd_stop_t           resolved_mode;

   // stop mode from the incoming word's bits 7..9
   fcd_stop_resolve u_stop
   (
      .sel_ramp (cw_data[PT_SMRAMP]),
      .sel_fast (cw_data[PT_SMFAST]),
      .sel_free (cw_data[PT_SMFREE]),
      .cfg_mode (cfg_stop_mode),
      .mode     (resolved_mode)
   );

   // next values of the decoded control state
   always_comb
   begin
      profile_d       = prof_decode(profile_cfg);
      cw_taken_d      = 1'b0;
      cw_retained_d   = 1'b0;
      fault_reset_d   = 1'b0;
      control_word_d  = control_word_q;
      reference_d     = reference_q;
      bus_ctrl_en_d   = bus_ctrl_en_q;
      ref_locked_d    = ref_locked_q;
      ramp_locked_d   = ramp_locked_q;
      jog1_d          = jog1_q;
      jog2_d          = jog2_q;
      ext_loc_d       = external_location_select_q;
      user_bits_d     = user_bits_q;
      internal_cw_d   = internal_cw_q;
      stop_req_d      = stop_req_q;
      stop_mode_d     = stop_mode_q;
      start_req_d     = start_req_q;
      reverse_req_d   = reverse_req_q;
      run_enable_d    = run_enable_q;
      ramp_out_zero_d = ramp_out_zero_q;
      ramp_hold_d     = ramp_hold_q;
      ramp_in_zero_d  = ramp_in_zero_q;
      take_cmd_d      = bus_takeover_command_q;
      take_ref_d      = bus_takeover_reference_q;
      reserved_seen_d = reserved_seen_q;
      reset_bit_d     = reset_bit_q;

      if (profile_d != profile_q)
      begin
         // profile switch: drop every decoded request
         control_word_d  = CW_RST;
         reference_d     = REF_RST;
         bus_ctrl_en_d   = 1'b0;
         ref_locked_d    = 1'b0;
         ramp_locked_d   = 1'b0;
         jog1_d          = 1'b0;
         jog2_d          = 1'b0;
         ext_loc_d       = 1'b0;
         user_bits_d     = USER_RST;
         internal_cw_d   = CW_RST;
         stop_req_d      = 1'b0;
         stop_mode_d     = SM_CONFIG;
         start_req_d     = 1'b0;
         reverse_req_d   = 1'b0;
         run_enable_d    = RUN_RST;
         ramp_out_zero_d = 1'b0;
         ramp_hold_d     = 1'b0;
         ramp_in_zero_d  = 1'b0;
         take_cmd_d      = 1'b0;
         take_ref_d      = 1'b0;
         reserved_seen_d = 1'b0;
         reset_bit_d     = 1'b0;
      end
      else if (cw_valid)
      begin
         case (profile_q)
            PROF_CONV:
            begin
               if (cw_data[CV_REMOTE])
               begin
                  // bus control, word and reference taken
                  cw_taken_d     = 1'b1;
                  bus_ctrl_en_d  = 1'b1;
                  ref_locked_d   = 1'b0;
                  ramp_locked_d  = 1'b0;
               end
               else if (cw_data == CW_RST && ref_data == REF_RST)
               begin
                  // all zero: control on, reference and ramps locked
                  cw_taken_d     = 1'b1;
                  bus_ctrl_en_d  = 1'b1;
                  ref_locked_d   = 1'b1;
                  ramp_locked_d  = 1'b1;
               end
               else
               begin
                  cw_retained_d  = 1'b1;
               end
               if (cw_taken_d)
               begin
                  control_word_d = cw_data;
                  reference_d    = ref_data;
                  jog1_d    = src_gate(jog_src_bus, cw_data[CV_JOG1]);
                  jog2_d    = src_gate(jog_src_bus, cw_data[CV_JOG2]);
                  ext_loc_d = src_gate(loc_src_bus, cw_data[CV_EXTLOC]);
                  user_bits_d = cw_data[CV_USER +: USER_W];
               end
            end
            PROF_PASS:
            begin
               cw_taken_d     = 1'b1;
               control_word_d = cw_data;
               reference_d    = ref_data;
               bus_ctrl_en_d  = 1'b1;
               ref_locked_d   = 1'b0;
               ramp_locked_d  = 1'b0;
               // low half copied as is, upper half zero
               internal_cw_d  = {{(CW_W-LOW_W){1'b0}}, cw_data[LOW_W-1:0]};
               stop_req_d     = cw_data[PT_STOP];
               stop_mode_d    = resolved_mode;
               start_req_d    = cw_data[PT_START];
               reverse_req_d  = cw_data[PT_REV];
               // fault reset on a 0 to 1 step between words
               fault_reset_d  = cw_data[PT_RESET] & ~reset_bit_q
                                & fault_active;
               reset_bit_d    = cw_data[PT_RESET];
               ext_loc_d = src_gate(loc_src_bus, cw_data[PT_EXTLOC]);
               run_enable_d = run_src_bus ? ~cw_data[PT_RUNDIS] : RUN_RST;
               ramp_out_zero_d = cw_data[PT_ROZERO];
               ramp_hold_d     = cw_data[PT_RHOLD];
               ramp_in_zero_d  = cw_data[PT_RIZERO];
               take_cmd_d      = cw_data[PT_TKCMD];
               take_ref_d      = cw_data[PT_TKREF];
               user_bits_d     = cw_data[PT_USER +: USER_W];
               // reserved bits raise an observation flag; bits 3, 10, 15 also pass into the internal word
               reserved_seen_d = |(cw_data & PT_RSVD_MASK);
               jog1_d          = 1'b0;
               jog2_d          = 1'b0;
            end
            default:
            begin
               cw_taken_d = 1'b0;    // unknown profile: words ignored
            end
         endcase
      end
   end

   // registers of the decoded control state
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         profile_q                  <= PROF_NONE;
         cw_taken_q                 <= 1'b0;
         cw_retained_q              <= 1'b0;
         control_word_q             <= CW_RST;
         reference_q                <= REF_RST;
         bus_ctrl_en_q              <= 1'b0;
         ref_locked_q               <= 1'b0;
         ramp_locked_q              <= 1'b0;
         jog1_q                     <= 1'b0;
         jog2_q                     <= 1'b0;
         external_location_select_q <= 1'b0;
         user_bits_q                <= USER_RST;
         internal_cw_q              <= CW_RST;
         stop_req_q                 <= 1'b0;
         stop_mode_q                <= SM_CONFIG;
         start_req_q                <= 1'b0;
         reverse_req_q              <= 1'b0;
         fault_reset_q              <= 1'b0;
         run_enable_q               <= RUN_RST;
         ramp_out_zero_q            <= 1'b0;
         ramp_hold_q                <= 1'b0;
         ramp_in_zero_q             <= 1'b0;
         bus_takeover_command_q     <= 1'b0;
         bus_takeover_reference_q   <= 1'b0;
         reserved_seen_q            <= 1'b0;
         reset_bit_q                <= 1'b0;
      end
      else
      begin
         profile_q                  <= profile_d;
         cw_taken_q                 <= cw_taken_d;
         cw_retained_q              <= cw_retained_d;
         control_word_q             <= control_word_d;
         reference_q                <= reference_d;
         bus_ctrl_en_q              <= bus_ctrl_en_d;
         ref_locked_q               <= ref_locked_d;
         ramp_locked_q              <= ramp_locked_d;
         jog1_q                     <= jog1_d;
         jog2_q                     <= jog2_d;
         external_location_select_q <= ext_loc_d;
         user_bits_q                <= user_bits_d;
         internal_cw_q              <= internal_cw_d;
         stop_req_q                 <= stop_req_d;
         stop_mode_q                <= stop_mode_d;
         start_req_q                <= start_req_d;
         reverse_req_q              <= reverse_req_d;
         fault_reset_q              <= fault_reset_d;
         run_enable_q               <= run_enable_d;
         ramp_out_zero_q            <= ramp_out_zero_d;
         ramp_hold_q                <= ramp_hold_d;
         ramp_in_zero_q             <= ramp_in_zero_d;
         bus_takeover_command_q     <= take_cmd_d;
         bus_takeover_reference_q   <= take_ref_d;
         reserved_seen_q            <= reserved_seen_d;
         reset_bit_q                <= reset_bit_d;
      end
   end

endmodule

// ==== dv/fcd_decoder_monitor.sv ====
// Purpose: concurrent checks on the decoder outputs
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every decoder instance
`timescale 1ns/1ps
module fcd_decoder_monitor
   import fcd_pkg::*;
(
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              cw_valid,
   input wire logic [CW_W-1:0]   cw_data,
   input wire logic [REF_W-1:0]  ref_data,
   input wire logic              jog_src_bus,
   input wire logic              run_src_bus,
   input wire fcd_stop_t         cfg_stop_mode,
   input wire logic              fault_active,
   input wire fcd_prof_t         profile_q,
   input wire logic              cw_taken_q,
   input wire logic              cw_retained_q,
   input wire logic [CW_W-1:0]   control_word_q,
   input wire logic [REF_W-1:0]  reference_q,
   input wire logic              bus_ctrl_en_q,
   input wire logic              ref_locked_q,
   input wire logic              ramp_locked_q,
   input wire logic              jog1_q,
   input wire logic              jog2_q,
   input wire logic [CW_W-1:0]   internal_cw_q,
   input wire logic              stop_req_q,
   input wire fcd_stop_t         stop_mode_q,
   input wire logic              start_req_q,
   input wire logic              reverse_req_q,
   input wire logic              fault_reset_q,
   input wire logic              run_enable_q
);
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   // an accepted word in each profile
   sequence pass_take;
      profile_q == PROF_PASS && cw_taken_q;
   endsequence
   sequence conv_take;
      profile_q == PROF_CONV && cw_taken_q;
   endsequence

   // accept pulse, copy and command bits
   taken_cause_a:
      assert property (cw_taken_q |-> $past(cw_valid)) else $error("taken without strobe");
   pass_copy_a:
      assert property (pass_take |-> internal_cw_q == {16'h0000, $past(cw_data[15:0])})
      else $error("internal word not copied");
   pass_cmds_a:
      assert property (pass_take |-> {reverse_req_q, start_req_q, stop_req_q} == $past(cw_data[2:0]))
      else $error("stop start reverse wrong");
   run_enable_a:
      assert property (pass_take |-> run_enable_q == !($past(run_src_bus) && $past(cw_data[6])))
      else $error("run enable wrong");
   fault_pulse_a:
      assert property (fault_reset_q |-> $past(cw_data[4] && fault_active && cw_valid) ##1 !fault_reset_q)
      else $error("fault reset pulse wrong");
   stop_default_a:
      assert property (pass_take ##0 $past(cw_data[9:7]) == 3'h0 |-> stop_mode_q ==
         ($past(cfg_stop_mode) == SM_CONFIG ? SM_RAMP : $past(cfg_stop_mode)))
      else $error("configured stop mode not used");
   conv_jog_a:
      assert property (conv_take |-> {jog2_q, jog1_q} == ($past(cw_data[9:8]) & {2{$past(jog_src_bus)}}))
      else $error("jog request wrong");
   retain_a:
      assert property (cw_retained_q |-> !$past(cw_data[10]) && $stable(control_word_q) && $stable(reference_q))
      else $error("retained word changed state");
   zero_lock_a:
      assert property (conv_take ##0 $past(cw_data) == 0 && $past(ref_data) == 0
         |-> ref_locked_q && ramp_locked_q && bus_ctrl_en_q) else $error("zero word not locked");
endmodule

bind fcd_decoder fcd_decoder_monitor u_fcd_decoder_monitor (.clk_sys, .rst, .cw_valid, .cw_data,
   .ref_data, .jog_src_bus, .run_src_bus, .cfg_stop_mode, .fault_active, .profile_q, .cw_taken_q,
   .cw_retained_q, .control_word_q, .reference_q, .bus_ctrl_en_q, .ref_locked_q, .ramp_locked_q,
   .jog1_q, .jog2_q, .internal_cw_q, .stop_req_q, .stop_mode_q, .start_req_q, .reverse_req_q,
   .fault_reset_q, .run_enable_q);

// ==== dv/fcd_master_model.sv ====
// Purpose: fieldbus master that writes control words
// Assumes: one strobed word and reference per send
// Notes:   data lines carry inverted junk between words
`timescale 1ns/1ps
module fcd_master_model
   import fcd_pkg::*;
(
   input  wire logic         clk_sys,
   input  wire logic         strict,
   output logic              cw_valid,
   output logic [CW_W-1:0]   cw_data,
   output logic [REF_W-1:0]  ref_data
);
   // idle at time zero
   initial
   begin
      cw_valid = 1'b0;
      cw_data  = 32'h0;
      ref_data = 16'h0;
   end

   // one-cycle strobe, then drive inverted junk on the data lines
   task automatic send(input logic [CW_W-1:0] w, input logic [REF_W-1:0] r);
      @(posedge clk_sys);
      cw_valid <= 1'b1;
      cw_data  <= strict ? (w & ~PT_RSVD_MASK) : w;
      ref_data <= r;
      @(posedge clk_sys);
      cw_valid <= 1'b0;
      cw_data  <= ~w;  // stale value must not be trusted
      ref_data <= ~r;
   endtask
endmodule

// ==== dv/fcd_decoder_tb.sv ====
// Purpose: directed tests of both control word profiles
// Assumes: 200 MHz clock, results one cycle after the strobe
// Notes:   the master model owns the word strobe
`timescale 1ns/1ps
module fcd_decoder_tb
   import fcd_pkg::*;
;
   logic              clk_sys, rst, jog_src_bus, loc_src_bus, run_src_bus, fault_active, strict;
   logic [PROF_W-1:0] profile_cfg;
   logic              cw_valid;
   logic [CW_W-1:0]   cw_data, control_word_q, internal_cw_q;
   logic [REF_W-1:0]  ref_data, reference_q;
   fcd_stop_t         cfg_stop_mode, stop_mode_q;
   fcd_prof_t         profile_q;
   logic              cw_taken_q, cw_retained_q, bus_ctrl_en_q, ref_locked_q, ramp_locked_q;
   logic              jog1_q, jog2_q, external_location_select_q, stop_req_q, start_req_q;
   logic              reverse_req_q, fault_reset_q, run_enable_q, ramp_out_zero_q, ramp_hold_q;
   logic              ramp_in_zero_q, bus_takeover_command_q, bus_takeover_reference_q;
   logic              reserved_seen_q;
   logic [USER_W-1:0] user_bits_q;
   int                err_count, n_tests;
   logic [2:0]        sel [6] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
   fcd_stop_t         cfgs [6] = '{SM_FAST, SM_CONFIG, SM_FAST, SM_FAST, SM_FAST, SM_RAMP};
   fcd_stop_t         exps [6] = '{SM_FAST, SM_RAMP, SM_RAMP, SM_FAST, SM_FREE, SM_FREE};

   fcd_decoder u_fcd_decoder (.clk_sys, .rst, .profile_cfg, .cw_valid, .cw_data, .ref_data,
      .jog_src_bus, .loc_src_bus, .run_src_bus, .cfg_stop_mode, .fault_active, .profile_q,
      .cw_taken_q, .cw_retained_q, .control_word_q, .reference_q, .bus_ctrl_en_q, .ref_locked_q,
      .ramp_locked_q, .jog1_q, .jog2_q, .external_location_select_q, .user_bits_q, .internal_cw_q,
      .stop_req_q, .stop_mode_q, .start_req_q, .reverse_req_q, .fault_reset_q, .run_enable_q,
      .ramp_out_zero_q, .ramp_hold_q, .ramp_in_zero_q, .bus_takeover_command_q,
      .bus_takeover_reference_q, .reserved_seen_q);
   fcd_master_model u_fcd_master_model (.clk_sys, .strict, .cw_valid, .cw_data, .ref_data);

   // 200 MHz clock
   always #2.5 clk_sys = ~clk_sys;

   // compare one result
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("FAIL %0t %s", $time, m);
      end
   endtask

   // send a word and let the answering edge land
   task automatic wr(input logic [31:0] w, input logic [15:0] r);
      u_fcd_master_model.send(w, r);
      #1;
   endtask

   // verdict and end of run
   task automatic conclude();
      if (err_count == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // watchdog well beyond the expected run
   initial
   begin
      repeat (2000) @(posedge clk_sys);
      err_count++;
      conclude();
   end

   // main sequence
   initial
   begin
      {clk_sys, rst, jog_src_bus, loc_src_bus, run_src_bus, fault_active, strict} = 7'h20;
      profile_cfg = 8'h00;
      cfg_stop_mode = SM_CONFIG;
      repeat (3) @(posedge clk_sys);
      #1;
      chk(run_enable_q, 1, "reset run enable");
      chk(profile_q, PROF_NONE, "reset profile");
      @(posedge clk_sys);
      rst <= 1'b0;
      jog_src_bus <= 1'b1;
      loc_src_bus <= 1'b1;
      repeat (2) @(posedge clk_sys);
      chk(profile_q, PROF_CONV, "converting profile");
      wr(32'h0000_0500, 16'h0005);
      chk({cw_taken_q, bus_ctrl_en_q, jog1_q, jog2_q}, 4'hE, "jog1 remote");
      chk(reference_q, 16'h0005, "reference");
      chk(internal_cw_q, 32'h0, "internal word in converting");
      wr(32'h0000_AE00, 16'h0001);
      chk({jog1_q, jog2_q, external_location_select_q, user_bits_q}, 7'h3A, "jog2 second_external_location");
      @(posedge clk_sys);
      jog_src_bus <= 1'b0;
      loc_src_bus <= 1'b0;
      wr(32'h0000_5F00, 16'h0002);
      chk({jog1_q, jog2_q, external_location_select_q, user_bits_q}, 7'h05, "gated sources");
      wr(32'h0000_0001, 16'h0000);
      chk({cw_retained_q, cw_taken_q}, 2'h2, "retain pulse");
      chk(control_word_q, 32'h0000_5F00, "retained word");
      chk(reference_q, 16'h0002, "retained reference");
      wr(32'h0, 16'h0000);
      chk({bus_ctrl_en_q, ref_locked_q, ramp_locked_q}, 3'h7, "zero word locks");
      @(posedge clk_sys);
      profile_cfg <= 8'h05;
      {loc_src_bus, run_src_bus, fault_active, strict} <= 4'hF;
      repeat (3) @(posedge clk_sys);
      #1;
      chk({profile_q, bus_ctrl_en_q, run_enable_q}, {PROF_PASS, 2'h1}, "pass profile clears");
      wr(32'h00C3_38F7, 16'h0009);
      chk(internal_cw_q, 32'h0000_38F7, "copied low half");
      chk({stop_req_q, start_req_q, reverse_req_q, fault_reset_q}, 4'hF, "commands");
      chk({external_location_select_q, run_enable_q, stop_mode_q}, {2'h2, SM_RAMP}, "loc run");
      chk({ramp_out_zero_q, ramp_hold_q, ramp_in_zero_q}, 3'h7, "ramp control");
      chk({bus_takeover_command_q, bus_takeover_reference_q}, 2'h3, "takeover");
      chk(user_bits_q, 4'h3, "pass user bits");
      wr(32'h00C3_38F7, 16'h0009);
      chk(fault_reset_q, 1'b0, "steady reset bit");
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk_sys);
         run_src_bus <= 1'b0;
         cfg_stop_mode <= cfgs[i];
         wr({22'h0, sel[i], 7'h41}, 16'h0000);
         chk({stop_req_q, run_enable_q, stop_mode_q}, {2'h3, exps[i]}, "stop mode");
      end
      @(posedge clk_sys);
      strict <= 1'b0;
      wr(PT_RSVD_MASK, 16'h0000);
      chk(internal_cw_q, 32'h0000_8408, "reserved copied");
      chk({stop_req_q, start_req_q, ramp_out_zero_q, user_bits_q}, 7'h00, "reserved inert");
      chk(reserved_seen_q, 1'b1, "reserved seen");
      @(posedge clk_sys);
      profile_cfg <= 8'h03;
      repeat (3) @(posedge clk_sys);
      wr(32'h0000_0002, 16'h0000);
      chk({profile_q, cw_taken_q, start_req_q}, {PROF_NONE, 2'h0}, "unknown profile");
      conclude();
   end
endmodule
